// file: txsq_defs.svh
// constants for the transmit status / fifo / sequence register slice
// assumes a 32-bit apb bus, byte addresses, one register per aligned word
// How it works
// - crc flag set while checksum goes out
// - delimiter flag set after start delimiter sent
// - delimiter flag cleared by any reset or receive go
// - with checksum, delimiter clears after last bit
// - reserved status bit 5 written zero, reads zero
// - status bits 4:1 give free slots, reset 8
// - fifo holds eight bytes, 8 empty, 0 full
// - busy set at start until transmission completes
// - clock pin input: busy until both fifos empty
// - writes to transmit status are ignored
// - port write pushes byte, advances write pointer
// - port read pops byte, advances read pointer
// - bit 7 drives receive clock pin when enabled
// - bit 6 drives user6 pin when mux allows
// - bit 5 drives user5 pin when mux allows
// - bit 4 drives link lock pin by mode
// - bit 3 selects register-controlled pin timing
// - bit 2 governs modulation timing of command pin
// - bit 1 sets transmit power enable level
// - bit 0 sets true and complemented command pins
`ifndef TXSQ_DEFS_SVH
`define TXSQ_DEFS_SVH

`define TXSQ_OFF_STATUS 12'h000
`define TXSQ_OFF_FIFO 12'h004
`define TXSQ_OFF_SEQ 12'h008
`define TXSQ_OFF_CMD 12'h00c
`define TXSQ_OFF_MUX 12'h010

`define TXSQ_ST_CRC 7
`define TXSQ_ST_SDD 6
`define TXSQ_ST_RSVD 5
`define TXSQ_ST_FREE_HI 4
`define TXSQ_ST_FREE_LO 1
`define TXSQ_ST_BUSY 0

`define TXSQ_SEQ_RXC 7
`define TXSQ_SEQ_USER6 6
`define TXSQ_SEQ_USER5 5
`define TXSQ_SEQ_LLOCK 4
`define TXSQ_SEQ_RTIM 3
`define TXSQ_SEQ_MOD 2
`define TXSQ_SEQ_PE 1
`define TXSQ_SEQ_CMD 0

`define TXSQ_CMD_START 0
`define TXSQ_CMD_TX_RST 1
`define TXSQ_CMD_RX_RST 2
`define TXSQ_CMD_RX_GO 3
`define TXSQ_CMD_SOFT 4
`define TXSQ_CMD_CORE 5

`define TXSQ_MUX_RXC_EN 0
`define TXSQ_MUX_RXC_FN 1
`define TXSQ_MUX_U6_EN 2
`define TXSQ_MUX_U6_FN 3
`define TXSQ_MUX_U5_EN 4
`define TXSQ_MUX_U5_FN 5
`define TXSQ_MUX_LL_EN 6

`define TXSQ_FIFO_DEPTH 8
`define TXSQ_SEQ_RESET 8'h00
`define TXSQ_MUX_RESET 8'h00

`endif

// file: txsq_pkg.sv
// types for the transmit register slice
// assumes txsq_defs.svh is included by the design files
`default_nettype none
package txsq_pkg;

  // status and requests coming back from the transmit serializer
  typedef struct packed {
    logic pop;
    logic crc_active;
    logic sfd_done;
    logic frame_done;
    logic serial_empty;
    logic tclk_input;
  } txsq_ser_in_t;

  // sequence pin levels toward the pin multiplexer
  typedef struct packed {
    logic reg_timing;
    logic mod_ctl;
    logic pe;
    logic cmd;
    logic cmd_n;
  } txsq_seq_pins_t;

  typedef enum logic [1:0] {
    TXSQ_IDLE,
    TXSQ_SEND,
    TXSQ_DRAIN
  } txsq_state_t;

endpackage
`default_nettype wire

// file: txsq_regs.sv
// transmit status, transmit fifo port and sequence control registers
// assumes a synchronous apb master on pclk and a serializer on the same clock
//
// Added by the designer: the address map and the APB slave port.
`include "txsq_defs.svh"
`default_nettype none
module txsq_regs
  import txsq_pkg::*;
#(
  parameter int DEPTH = `TXSQ_FIFO_DEPTH
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serializer side
  input wire txsq_ser_in_t ser_in,
  output logic ser_pop_ready,
  output logic [7:0] ser_data,
  output logic ser_data_valid,
  output logic tx_start_pulse,
  output logic tx_abort,
  // mode inputs from the bus interface and plug-and-play logic
  input wire logic isa_mode,
  input wire logic user6_pnp_free,
  input wire logic user5_pnp_free,
  // multiplexed pins, output enable active low
  input wire logic rxc_pin_i,
  output logic rxc_pin_o,
  output logic rxc_pin_oe_n,
  input wire logic user6_pin_i,
  output logic user6_pin_o,
  output logic user6_pin_oe_n,
  input wire logic user5_pin_i,
  output logic user5_pin_o,
  output logic user5_pin_oe_n,
  input wire logic llock_pin_i,
  output logic llock_pin_o,
  output logic llock_pin_oe_n,
  // transmit sequence pins
  output txsq_seq_pins_t seq_pins
);

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setup;
  logic wr_acc;
  logic hit_status;
  logic hit_fifo;
  logic hit_seq;
  logic hit_cmd;
  logic hit_mux;
  logic mapped;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_status = (paddr == `TXSQ_OFF_STATUS);
  assign hit_fifo = (paddr == `TXSQ_OFF_FIFO);
  assign hit_seq = (paddr == `TXSQ_OFF_SEQ);
  assign hit_cmd = (paddr == `TXSQ_OFF_CMD);
  assign hit_mux = (paddr == `TXSQ_OFF_MUX);
  assign mapped = hit_status | hit_fifo | hit_seq | hit_cmd | hit_mux;
  // zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [7:0] seq;
  logic [7:0] mux;
  logic [5:0] cmd;
  logic start_q;
  logic core_clr;
  logic sdd_clr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      seq <= `TXSQ_SEQ_RESET;
    else if (wr_acc && hit_seq)
      seq <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mux <= `TXSQ_MUX_RESET;
    else if (wr_acc && hit_mux)
      mux <= pwdata[7:0];
  end

  // reset style bits self clear; the start bit is a held level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd <= 6'h0;
    else if (wr_acc && hit_cmd)
      cmd <= pwdata[5:0];
    else
      cmd <= {cmd[5:1] & 5'h0, cmd[`TXSQ_CMD_START]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_q <= 1'b0;
    else
      start_q <= cmd[`TXSQ_CMD_START];
  end

  // only a fresh rising edge of the start bit launches a frame
  assign tx_start_pulse = cmd[`TXSQ_CMD_START] & ~start_q;
  assign core_clr = cmd[`TXSQ_CMD_CORE] | cmd[`TXSQ_CMD_SOFT] | cmd[`TXSQ_CMD_TX_RST];
  assign tx_abort = core_clr;
  assign sdd_clr = core_clr | cmd[`TXSQ_CMD_RX_RST] | cmd[`TXSQ_CMD_RX_GO];

  //////////////////////////////////////////////////////////////////////////////
  // transmit fifo

  logic [7:0] mem [DEPTH];
  logic [2:0] wptr;
  logic [2:0] rptr;
  logic [3:0] free;
  logic full;
  logic empty;
  logic push;
  logic apb_pop;
  logic pop;

  assign full = (free == 4'h0);
  assign empty = (free == 4'(DEPTH));
  assign push = wr_acc && hit_fifo && !full;
  // a diagnostic read pops in its setup cycle, ahead of the serializer
  assign apb_pop = setup && !pwrite && hit_fifo && !empty;
  assign ser_pop_ready = !apb_pop && !empty;
  assign pop = apb_pop | (ser_in.pop & ser_pop_ready);
  assign ser_data = mem[rptr];
  assign ser_data_valid = !empty;

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wptr] <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      free <= 4'h8;
    end
    else if (core_clr)
    begin
      wptr <= 3'h0;
      rptr <= 3'h0;
      free <= 4'(DEPTH);
    end
    else
    begin
      if (push)
        wptr <= wptr + 3'h1;
      if (pop)
        rptr <= rptr + 3'h1;
      if (push && !pop)
        free <= free - 4'h1;
      else if (pop && !push)
        free <= free + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit status

  txsq_state_t state;
  logic crc_flag;
  logic sdd_flag;
  logic busy;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= TXSQ_IDLE;
    else if (core_clr)
      state <= TXSQ_IDLE;
    else
      case (state)
        TXSQ_IDLE:
          if (tx_start_pulse)
            state <= TXSQ_SEND;
        TXSQ_SEND:
          if (ser_in.frame_done)
            state <= ser_in.tclk_input ? TXSQ_DRAIN : TXSQ_IDLE;
        TXSQ_DRAIN:
          if (empty && ser_in.serial_empty)
            state <= TXSQ_IDLE;
        default:
          state <= TXSQ_IDLE;
      endcase
  end

  assign busy = (state != TXSQ_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crc_flag <= 1'b0;
    else
      crc_flag <= ser_in.crc_active & ~core_clr;
  end

  // clears when the checksum ends, so after its last bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sdd_flag <= 1'b0;
    else if (sdd_clr)
      sdd_flag <= 1'b0;
    else if (ser_in.sfd_done)
      sdd_flag <= 1'b1;
    else if (crc_flag && !ser_in.crc_active)
      sdd_flag <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pins

  always_comb
  begin
    rxc_pin_o = seq[`TXSQ_SEQ_RXC];
    rxc_pin_oe_n = ~(mux[`TXSQ_MUX_RXC_EN] & ~mux[`TXSQ_MUX_RXC_FN]);
    user6_pin_o = seq[`TXSQ_SEQ_USER6];
    user6_pin_oe_n = ~(mux[`TXSQ_MUX_U6_EN] & ~mux[`TXSQ_MUX_U6_FN]
                       & user6_pnp_free);
    user5_pin_o = seq[`TXSQ_SEQ_USER5];
    user5_pin_oe_n = ~(mux[`TXSQ_MUX_U5_EN] & ~mux[`TXSQ_MUX_U5_FN]
                       & user5_pnp_free);
    // in isa mode the pin is an address input and never driven
    llock_pin_o = seq[`TXSQ_SEQ_LLOCK];
    llock_pin_oe_n = ~(mux[`TXSQ_MUX_LL_EN] & ~isa_mode);
    seq_pins.reg_timing = seq[`TXSQ_SEQ_RTIM];
    seq_pins.mod_ctl = seq[`TXSQ_SEQ_MOD];
    seq_pins.pe = seq[`TXSQ_SEQ_PE];
    seq_pins.cmd = seq[`TXSQ_SEQ_CMD];
    seq_pins.cmd_n = ~seq[`TXSQ_SEQ_CMD];
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle

  logic [7:0] rd;

  always_comb
  begin
    rd = 8'h00;
    if (hit_status)
      rd = {crc_flag, sdd_flag, 1'b0, free, busy};
    else if (hit_fifo)
      rd = empty ? 8'h00 : mem[rptr];
    else if (hit_seq)
      rd = {rxc_pin_i, user6_pin_i, user5_pin_i, llock_pin_i, seq[3:0]};
    else if (hit_cmd)
      rd = {2'b00, cmd};
    else if (hit_mux)
      rd = mux;
  end

  // status has no write path at all
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= {24'h00_0000, rd};
  end

endmodule
`default_nettype wire

// file: txsq_regs_properties.sv
// checker for the transmit register slice, port level only
// assumes reads load prdata at the setup edge
`default_nettype none
module txsq_regs_properties
  import txsq_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // transmit side and pins
  input wire txsq_ser_in_t ser_in,
  input wire logic tx_start_pulse,
  input wire logic isa_mode,
  input wire logic rxc_pin_o,
  input wire logic rxc_pin_oe_n,
  input wire logic llock_pin_oe_n,
  input wire txsq_seq_pins_t seq_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic rd_st = psel && !penable && !pwrite && paddr == 12'h000;
  wire logic wr_sq = psel && penable && pwrite && paddr == 12'h008;
  ////////////////////////////////////////////////////////////////
  a_crc_flag: assert property (rd_st |=> prdata[7] == $past(ser_in.crc_active, 2))
    else $error("crc flag");
  a_rsvd_zero: assert property (rd_st |=> !prdata[5] && prdata[31:8] == '0)
    else $error("reserved bits");
  a_free_max: assert property (rd_st |=> prdata[4:1] <= 4'h8)
    else $error("free count");
  a_busy_start: assert property (tx_start_pulse ##[1:2] rd_st |=> prdata[0])
    else $error("busy flag");
  a_rxc_drive: assert property (wr_sq |=> rxc_pin_oe_n || rxc_pin_o == $past(pwdata[7]))
    else $error("rxc pin");
  a_llock_isa: assert property (isa_mode |-> llock_pin_oe_n)
    else $error("llock pin");
  a_seq_bits: assert property (wr_sq |=> seq_pins[4:1] == $past(pwdata[3:0]))
    else $error("sequence pins");
  a_cmd_pair: assert property (seq_pins.cmd_n == !seq_pins.cmd)
    else $error("command pair");
  a_start_once: assert property (tx_start_pulse |=> !tx_start_pulse)
    else $error("start pulse");
endmodule
bind txsq_regs txsq_regs_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .ser_in, .tx_start_pulse, .isa_mode, .rxc_pin_o,
  .rxc_pin_oe_n, .llock_pin_oe_n, .seq_pins);
`default_nettype wire

// file: txsq_ser_model.sv
// serializer stand-in: delimiter, payload pops, checksum, drain tail
// assumes the register slice on the same clock
`default_nettype none
module txsq_ser_model
  import txsq_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register slice side
  input wire logic start,
  input wire logic pop_ready,
  input wire logic valid,
  input wire logic [7:0] data,
  // bench controls
  input wire logic slow,
  input wire logic tclk_in,
  output wire txsq_ser_in_t ser
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] st;
  logic tg;
  logic [7:0] got [$];
  // st 1 delimiter, 2 payload, 3-6 checksum, 7 done, 8-11 serial drain
  assign ser = {st == 4'h2 && (tg || !slow), st >= 4'h3 && st <= 4'h6, st == 4'h1,
    st == 4'h7, st == 4'h0, tclk_in};
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st <= 4'h0;
      tg <= 1'b0;
    end
    else
    begin
      tg <= ~tg;
      if (ser.pop && pop_ready)
        got.push_back(data);
      if (st == 4'h0)
        st <= {3'b000, start};
      else if (st == 4'h2)
        st <= valid ? st : 4'h3;
      else
        st <= (st == 4'hb) ? 4'h0 : st + 4'h1;
    end
endmodule
`default_nettype wire

// file: tx_status_fifo_sequence_regs_tb_top.sv
// bench for the transmit register slice
// assumes design, checker and serializer model compile first
`default_nettype none
module tx_status_fifo_sequence_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, prdy, dval, start, abort, er;
  logic isa = 1'b0, pnp = 1'b1, slow = 1'b0, tclk = 1'b0;
  logic [7:0] sdata, rd;
  logic [5:0] ser;
  logic [4:0] sp;
  logic [3:0] po, poe_n;
  wire logic [3:0] pw = po | poe_n;  // an undriven pin sits at its pull-up
  int err_total = 0, n_tests = 0, seed = 32'h35c4_adca, n_ab = 0;
  logic [7:0] q [$];
  always #5 pclk = ~pclk;
  // every abort command must reach the serializer as exactly one pulse
  always @(posedge pclk)
    if (abort === 1'b1)
      n_ab <= n_ab + 1;
  txsq_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ser_in(ser), .ser_pop_ready(prdy), .ser_data(sdata),
    .ser_data_valid(dval), .tx_start_pulse(start), .tx_abort(abort), .isa_mode(isa),
    .user6_pnp_free(pnp), .user5_pnp_free(pnp), .rxc_pin_i(pw[3]), .rxc_pin_o(po[3]),
    .rxc_pin_oe_n(poe_n[3]), .user6_pin_i(pw[2]), .user6_pin_o(po[2]),
    .user6_pin_oe_n(poe_n[2]), .user5_pin_i(pw[1]), .user5_pin_o(po[1]),
    .user5_pin_oe_n(poe_n[1]), .llock_pin_i(pw[0]), .llock_pin_o(po[0]),
    .llock_pin_oe_n(poe_n[0]), .seq_pins(sp));
  txsq_ser_model u_ser (.pclk, .presetn, .start, .pop_ready(prdy), .valid(dval),
    .data(sdata), .slow, .tclk_in(tclk), .ser);
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 200)
    begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 200);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    guard(n);
  endtask
  task automatic wait_st(input logic [3:0] s);
    int n;
    for (n = 0; u_ser.st !== s && n < 200; n++)
      @(posedge pclk);
    guard(n);
  endtask
  task automatic push(input int k);
    logic [7:0] b;
    repeat (k)
    begin
      b = 8'($random(seed));
      apb(1'b1, 12'h004, b);
      if (q.size() < 8)
        q.push_back(b);
    end
  endtask
  task automatic chk_st(input logic [7:0] e);
    apb(1'b0, 12'h000, 8'h00);
    `CHK(rd, e)
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] b, d;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk_st(8'h10);
    apb(1'b0, 12'h008, 8'h00);
    `CHK(rd, 8'hf0)
    apb(1'b1, 12'h000, 8'hdf);
    `CHK(er, 1'b0)
    chk_st(8'h10);
    for (int i = 1; i < 10; i++)
    begin
      push(1);
      chk_st({3'b000, (i > 8) ? 4'h0 : 4'(8 - i), 1'b0});
    end
    repeat (2)
    begin
      apb(1'b0, 12'h004, 8'h00);
      b = q.pop_front();
      `CHK(rd, b)
    end
    push(2);
    chk_st(8'h00);
    for (int t = 0; t < 2; t++)
    begin
      tclk <= t[0];
      slow <= t[0];
      apb(1'b1, 12'h00c, 8'h00);
      apb(1'b1, 12'h00c, 8'h01);
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rd[0], 1'b1)
      wait_st(4'h3);
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rd[7:6], 2'b11)
      wait_st(4'h9);
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rd[0], t[0])
      wait_st(4'h0);
      `CHK(u_ser.got.size(), q.size())
      foreach (q[i]) `CHK(u_ser.got[i], q[i])
      chk_st(8'h10);
      q.delete();
      u_ser.got.delete();
      push(3);
    end
    apb(1'b1, 12'h00c, 8'h01);
    chk_st(8'h0a);
    for (int k = 1; k < 6; k++)
    begin
      apb(1'b1, 12'h00c, 8'h00);
      push(3);
      apb(1'b1, 12'h00c, 8'h01);
      wait_st(4'h2);
      apb(1'b1, 12'h00c, 8'(1 << k) | 8'h01);
      apb(1'b0, 12'h000, 8'h00);
      `CHK(rd[6], 1'b0)
      `CHK(rd[0], k == 2 || k == 3)
      wait_st(4'h0);
    end
    apb(1'b1, 12'h010, 8'h55);
    repeat (6)
    begin
      b = 8'($random(seed));
      d = 8'($random(seed));
      isa <= b[0];
      pnp <= b[1];
      apb(1'b1, 12'h008, d);
      apb(1'b0, 12'h008, 8'h00);
      // sequence pins are looked at well after the write edge has settled them
      `CHK(sp, {d[3:0], ~d[0]})
      `CHK(rd, {d[7], b[1] ? d[6:5] : 2'b11, b[0] | d[4], d[3:0]})
    end
    `CHK(n_ab, 3)
    finish_test();
  end
endmodule
`default_nettype wire
